// [rtl/alpha_block_pkg.sv]
// constants for the compressed rgba block alpha decoder
package alpha_block_pkg;
	localparam int BLOCK_W = 128;
	localparam int WORD_W = 64;
	localparam int ALPHA_MSB = 127;
	localparam int ALPHA_LSB = 64;
	localparam int COLOUR_MSB = 63;
	localparam int COLOUR_LSB = 0;
	localparam int BASE_MSB = 63;
	localparam int BASE_LSB = 56;
	localparam int SCALE_MSB = 55;
	localparam int SCALE_LSB = 52;
	localparam int TABLE_MSB = 51;
	localparam int TABLE_LSB = 48;
	localparam int SEL_TOP = 47;
	localparam int SEL_W = 3;
	localparam int PIXELS = 16;
	localparam int CHAN_W = 8;
	localparam logic [9:0] CHAN_MAX = 10'h0FF;
	localparam int PIPE_LAT = 2;
	localparam logic [WORD_W-1:0] WORD_RST = 64'h0000000000000000;
	localparam logic [CHAN_W-1:0] CHAN_RST = 8'h00;
	typedef enum logic [1:0] {
		LINEAR_RGBA_BLOCK_FORMAT = 2'b01,
		SRGB_RGBA_BLOCK_FORMAT = 2'b10
	} block_format_type;
endpackage

// [rtl/alpha_offset_rom.sv]
// fixed signed offset tables indexed by table selector and pixel selector
`timescale 1ns/100ps
module alpha_offset_rom (
	input wire logic [3:0] tableSel,
	input wire logic [2:0] entrySel,
	output logic signed [4:0] offset
);
	logic signed [4:0] row [0:7];

	// entry zero is the leftmost table value
	always_comb begin
		unique case (tableSel)
			4'h0: row = '{-5'sd3, -5'sd6, -5'sd9, -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14};
			4'h1: row = '{-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12};
			4'h2: row = '{-5'sd2, -5'sd5, -5'sd8, -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12};
			4'h3: row = '{-5'sd2, -5'sd4, -5'sd6, -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12};
			4'h4: row = '{-5'sd3, -5'sd6, -5'sd8, -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11};
			4'h5: row = '{-5'sd3, -5'sd7, -5'sd9, -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10};
			4'h6: row = '{-5'sd4, -5'sd7, -5'sd8, -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10};
			4'h7: row = '{-5'sd3, -5'sd5, -5'sd8, -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10};
			4'h8: row = '{-5'sd2, -5'sd6, -5'sd8, -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9};
			4'h9: row = '{-5'sd2, -5'sd5, -5'sd8, -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9};
			4'hA: row = '{-5'sd2, -5'sd4, -5'sd8, -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9};
			4'hB: row = '{-5'sd2, -5'sd5, -5'sd7, -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9};
			4'hC: row = '{-5'sd3, -5'sd4, -5'sd7, -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9};
			4'hD: row = '{-5'sd1, -5'sd2, -5'sd3, -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9};
			4'hE: row = '{-5'sd4, -5'sd6, -5'sd8, -5'sd9, 5'sd3, 5'sd5, 5'sd7, 5'sd8};
			4'hF: row = '{-5'sd3, -5'sd5, -5'sd7, -5'sd9, 5'sd2, 5'sd4, 5'sd6, 5'sd8};
		endcase
	end

	assign offset = row[entrySel];
endmodule

// [rtl/rgba_block_alpha_decoder.sv]
// alpha path of a 128-bit compressed rgba 4x4 block, colour word passed on
`timescale 1ns/100ps
module rgba_block_alpha_decoder #(
	parameter int LATENCY = alpha_block_pkg::PIPE_LAT
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic blockValid,
	input wire logic [alpha_block_pkg::BLOCK_W-1:0] blockData,
	input wire alpha_block_pkg::block_format_type blockFormat,
	output logic [alpha_block_pkg::WORD_W-1:0] colourWord,
	output logic colourValid,
	output logic colourSrgb,
	output logic alphaValid,
	output logic [alpha_block_pkg::PIXELS*alpha_block_pkg::CHAN_W-1:0] alphaTexels
);
	localparam int CW = alpha_block_pkg::CHAN_W;
	localparam int NP = alpha_block_pkg::PIXELS;
	localparam int SW = alpha_block_pkg::SEL_W;

	initial begin
		if (LATENCY != 2) $error("LATENCY must be 2: two pipeline stages");
	end

	// split happens on the input edge
	logic [alpha_block_pkg::WORD_W-1:0] alphaWord_r;
	logic [alpha_block_pkg::WORD_W-1:0] colourWord_r;
	logic stage1Valid_r;
	logic stage1Srgb_r;
	logic [CW-1:0] alpha_r [0:NP-1];
	logic [CW-1:0] alpha_nxt [0:NP-1];
	logic stage2Valid_r;
	logic stage2Srgb_r;
	logic [alpha_block_pkg::WORD_W-1:0] colourOut_r;

	logic [CW-1:0] baseVal;
	logic [3:0] scaleVal;
	logic [3:0] tableSel;
	logic signed [4:0] offsetVal [0:NP-1];

	// saturate a signed sum into 0..255
	function automatic logic [CW-1:0] clampChan(input logic signed [9:0] s);
		if (s < 0) begin
			clampChan = alpha_block_pkg::CHAN_RST;
		end else if (s > $signed(alpha_block_pkg::CHAN_MAX)) begin
			clampChan = alpha_block_pkg::CHAN_MAX[CW-1:0];
		end else begin
			clampChan = s[CW-1:0];
		end
	endfunction

	always_ff @(posedge core_clk) begin
		if (srst) begin
			alphaWord_r <= alpha_block_pkg::WORD_RST;
			colourWord_r <= alpha_block_pkg::WORD_RST;
		end else if (blockValid) begin
			alphaWord_r <= blockData[alpha_block_pkg::ALPHA_MSB:
				alpha_block_pkg::ALPHA_LSB];
			colourWord_r <= blockData[alpha_block_pkg::COLOUR_MSB:
				alpha_block_pkg::COLOUR_LSB];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stage1Valid_r <= 1'b0;
			stage1Srgb_r <= 1'b0;
		end else begin
			stage1Valid_r <= blockValid;
			stage1Srgb_r <= blockValid &&
				(blockFormat == alpha_block_pkg::SRGB_RGBA_BLOCK_FORMAT);
		end
	end

	assign baseVal = alphaWord_r[alpha_block_pkg::BASE_MSB:
		alpha_block_pkg::BASE_LSB];
	assign scaleVal = alphaWord_r[alpha_block_pkg::SCALE_MSB:
		alpha_block_pkg::SCALE_LSB];
	assign tableSel = alphaWord_r[alpha_block_pkg::TABLE_MSB:
		alpha_block_pkg::TABLE_LSB];

	// format does not enter the alpha path at all
	for (genvar p = 0; p < NP; p++) begin : g_pix
		alpha_offset_rom u_rom (
			.tableSel(tableSel),
			// pixel p selector, msb at the higher bit
			.entrySel(alphaWord_r[alpha_block_pkg::SEL_TOP - SW*p -:
				SW]),
			.offset(offsetVal[p])
		);
	end

	// zero scale makes the product zero, no special case needed
	// (producer should not emit it but we decode it anyway)
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			alpha_nxt[p] = clampChan(
				$signed({2'b00, baseVal}) +
				offsetVal[p] * $signed({1'b0, scaleVal}));
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int p = 0; p < NP; p++) begin
				alpha_r[p] <= alpha_block_pkg::CHAN_RST;
			end
		end else if (stage1Valid_r) begin
			for (int p = 0; p < NP; p++) begin
				alpha_r[p] <= alpha_nxt[p];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stage2Valid_r <= 1'b0;
			stage2Srgb_r <= 1'b0;
			colourOut_r <= alpha_block_pkg::WORD_RST;
		end else begin
			stage2Valid_r <= stage1Valid_r;
			stage2Srgb_r <= stage1Srgb_r;
			if (stage1Valid_r) begin
				colourOut_r <= colourWord_r;
			end
		end
	end

	// slot p holds pixel letter p; column-major texel order
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			alphaTexels[CW*p +: CW] = alpha_r[p];
		end
	end

	assign alphaValid = stage2Valid_r;
	assign colourValid = stage2Valid_r;
	assign colourWord = colourOut_r;
	assign colourSrgb = stage2Srgb_r;
endmodule

// [dv/rgba_block_alpha_decoder_properties.sv]
// port assertions for the alpha block decoder
`timescale 1ns/100ps
module rgba_block_alpha_decoder_properties #(
	parameter int LATENCY = 2
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic blockValid,
	input wire logic [127:0] blockData,
	input wire alpha_block_pkg::block_format_type blockFormat,
	input wire logic [63:0] colourWord,
	input wire logic colourValid,
	input wire logic colourSrgb,
	input wire logic alphaValid,
	input wire logic [127:0] alphaTexels
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_take;
		blockValid ##2 1'h1;
	endsequence
	property p_lat; blockValid |-> ##2 alphaValid; endproperty
	property p_only; alphaValid |-> $past(blockValid, 2); endproperty
	property p_pair; colourValid == alphaValid; endproperty
	property p_hold; !alphaValid |-> $stable(alphaTexels); endproperty
	property p_col; s_take |-> colourWord == $past(blockData[63:0], 2);
	endproperty
	property p_srgb; s_take |-> colourSrgb == ($past(blockFormat, 2)
		== alpha_block_pkg::SRGB_RGBA_BLOCK_FORMAT); endproperty
	property p_base; s_take |-> $past(blockData[119:116], 2) != 4'h0
		|| alphaTexels == {16{$past(blockData[127:120], 2)}}; endproperty
	// base FF, scale F, selectors all 4: every sum is at least 255
	property p_sat; s_take |-> $past(blockData[127:116], 2) != 12'hFFF
		|| $past(blockData[111:64], 2) != 48'h924924924924
		|| alphaTexels == {16{8'hFF}}; endproperty
	a_lat: assert property (p_lat) else $error("late");
	a_only: assert property (p_only) else $error("spurious");
	a_pair: assert property (p_pair) else $error("unpaired");
	a_hold: assert property (p_hold) else $error("unheld");
	a_col: assert property (p_col) else $error("colour");
	a_srgb: assert property (p_srgb) else $error("srgb");
	a_base: assert property (p_base) else $error("zero scale");
	a_sat: assert property (p_sat) else $error("clamp");
endmodule
bind rgba_block_alpha_decoder rgba_block_alpha_decoder_properties #(
	.LATENCY(LATENCY)) i_props (.core_clk(core_clk), .srst(srst),
	.blockValid(blockValid), .blockData(blockData),
	.blockFormat(blockFormat), .colourWord(colourWord),
	.colourValid(colourValid), .colourSrgb(colourSrgb),
	.alphaValid(alphaValid), .alphaTexels(alphaTexels));

// [dv/block_fetch_model.sv]
// fetch side model presenting compressed blocks
`timescale 1ns/100ps
module block_fetch_model (
	input wire logic core_clk,
	output logic blockValid,
	output logic [127:0] blockData,
	output alpha_block_pkg::block_format_type blockFormat
);
	initial begin
		blockValid = 1'h0;
		blockData = 128'h0;
		blockFormat = alpha_block_pkg::LINEAR_RGBA_BLOCK_FORMAT;
	end
	// srgb format only when the bench asks for it
	task send(input logic [127:0] b, input logic s);
		@(negedge core_clk);
		blockValid = 1'h1;
		blockData = b;
		blockFormat = s ? alpha_block_pkg::SRGB_RGBA_BLOCK_FORMAT
			: alpha_block_pkg::LINEAR_RGBA_BLOCK_FORMAT;
	endtask
	// idle data inverted so stale values never look valid
	task idle();
		@(negedge core_clk);
		blockValid = 1'h0;
		blockData = ~blockData;
	endtask
endmodule

// [dv/tb_rgba_block_alpha_decoder.sv]
// self-checking bench for the alpha block decoder
`timescale 1ns/100ps
module tb_rgba_block_alpha_decoder;
	logic core_clk = 1'h0;
	logic srst = 1'h1;
	logic blockValid, colourValid, colourSrgb, alphaValid;
	logic [127:0] blockData, alphaTexels;
	alpha_block_pkg::block_format_type blockFormat;
	logic [63:0] colourWord;
	logic [127:0] qa[$];
	logic [64:0] qc[$];
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int tbl[128] = '{-3,-6,-9,-15,2,5,8,14,-3,-7,-10,-13,2,6,9,12,
		-2,-5,-8,-13,1,4,7,12,-2,-4,-6,-13,1,3,5,12,-3,-6,-8,-12,2,5,7,11,
		-3,-7,-9,-11,2,6,8,10,-4,-7,-8,-11,3,6,7,10,-3,-5,-8,-11,2,4,7,10,
		-2,-6,-8,-10,1,5,7,9,-2,-5,-8,-10,1,4,7,9,-2,-4,-8,-10,1,3,7,9,
		-2,-5,-7,-10,1,4,6,9,-3,-4,-7,-10,2,3,6,9,-1,-2,-3,-10,0,1,2,9,
		-4,-6,-8,-9,3,5,7,8,-3,-5,-7,-9,2,4,6,8};
	always #50 core_clk = ~core_clk;
	block_fetch_model i_block_fetch_model (.core_clk(core_clk),
		.blockValid(blockValid), .blockData(blockData),
		.blockFormat(blockFormat));
	rgba_block_alpha_decoder i_rgba_block_alpha_decoder (
		.core_clk(core_clk), .srst(srst), .blockValid(blockValid),
		.blockData(blockData), .blockFormat(blockFormat),
		.colourWord(colourWord), .colourValid(colourValid),
		.colourSrgb(colourSrgb), .alphaValid(alphaValid),
		.alphaTexels(alphaTexels));
	function automatic logic [127:0] expA(logic [127:0] b);
		int v;
		for (int k = 0; k < 16; k++) begin
			v = int'(b[127:120]) + int'(b[119:116])
				* tbl[{b[115:112], b[111-3*k -: 3]}];
			expA[8*k +: 8] = v < 0 ? 8'h00 : v > 255 ? 8'hFF : v[7:0];
		end
	endfunction
	task chk(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(posedge core_clk) if (!srst && blockValid) begin
		qa.push_back(expA(blockData));
		qc.push_back({blockFormat == 2'h2, blockData[63:0]});
	end
	always @(negedge core_clk) if (alphaValid === 1'h1) begin
		chk(alphaTexels, qa.pop_front());
		chk({colourValid, colourSrgb, colourWord},
			{1'h1, qc.pop_front()});
	end
	task drain(input string s);
		repeat (4) i_block_fetch_model.idle();
		$display("%s done", s);
	endtask
	task t_walk();
		i_block_fetch_model.send({8'h67, 4'h2, 4'hD, 48'h053977053977,
			64'h0123456789ABCDEF}, 1'h0);
		drain("t_walk");
	endtask
	task t_tables();
		for (int i = 0; i < 16; i++) i_block_fetch_model.send({8'h80,
			4'hF, 4'(i), 48'h053977053977, 64'(i)}, 1'(i));
		drain("t_tables");
	endtask
	task t_edges();
		i_block_fetch_model.send({8'h5A, 4'h0, 4'h7, 48'hFAC688FAC688,
			64'hFEDCBA9876543210}, 1'h1);
		i_block_fetch_model.send({12'hFFF, 4'h3, 48'h924924924924,
			64'h0}, 1'h0);
		drain("t_edges");
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge core_clk);
		srst = 1'h0;
		t_walk();
		t_tables();
		t_edges();
		chk(128'(qa.size()), 128'h0);
		report_and_stop();
	end
endmodule
